// ### shared/pcs_pkg.sv
// Package with the program counter, stack and indirect access constants and types.
package pcs_pkg;

  localparam int unsigned PC_WIDTH        = 13;
  localparam int unsigned PC_LOW_WIDTH    = 8;
  localparam int unsigned PC_HIGH_WIDTH   = PC_WIDTH - PC_LOW_WIDTH;
  localparam int unsigned JUMP_WIDTH      = 11;
  localparam int unsigned STACK_DEPTH     = 8;
  localparam int unsigned STACK_PTR_WIDTH = 3;
  localparam int unsigned FILE_ADDR_WIDTH = 8;
  localparam int unsigned BUS_ADDR_WIDTH  = 9;

  // Word addresses on the register bus; the byte address is four times the value.
  localparam logic [8:0] ADDR_PC_LOW_BYTE  = 9'h000;
  localparam logic [8:0] ADDR_PC_UPPER     = 9'h001;
  localparam logic [8:0] ADDR_IND_POINTER  = 9'h002;
  localparam logic [8:0] ADDR_IND_PORT     = 9'h003;
  localparam logic [8:0] ADDR_PC_STATUS    = 9'h004;
  localparam logic [8:0] ADDR_FILE_BASE    = 9'h100;

  // The data port sits at register-file address zero.
  localparam logic [7:0] FILE_ADDR_PORT    = 8'h00;

  // Field positions.
  localparam int unsigned LATCH_PAGE_BIT   = 3;
  localparam int unsigned LATCH_JUMP_LSB   = 3;
  localparam int unsigned POINTER_BANK_BIT = 8;

  // Reset values and the interrupt vector.
  localparam logic [12:0] PC_RESET         = 13'h0000;
  localparam logic [4:0]  LATCH_RESET      = 5'h00;
  localparam logic [7:0]  POINTER_RESET    = 8'h00;
  localparam logic [2:0]  STACK_PTR_RESET  = 3'h0;
  localparam logic [12:0] IRQ_VECTOR       = 13'h0004;

  // Instruction-side events presented by the sequencer, one cycle each.
  typedef struct packed {
    logic        fetch;
    logic        call;
    logic        jump;
    logic        ret;
    logic        irq;
    logic [10:0] target;
  } pcs_instr_type;

endpackage

// ### logic/pcs_core.sv
// Program counter, circular return stack and indirect register-file access.
//
// Behaviour
// - The program counter holding the next fetch address is 13 bits wide.
// - The low program-counter byte is readable and writable by software.
// - Upper five counter bits are not directly accessible; they come from the upper latch. The status word at ADDR_PC_STATUS reads all 13 bits.
// - Return stack is eight entries of 13 bits; its pointer is hidden from software.
// - Stack storage is outside every memory map; no access reaches it.
// - A call or an interrupt branch pushes the program counter.
// - Return, return with literal and return from interrupt pop into the counter.
// - Pushes and pops never modify the upper latch.
// - The stack wraps circularly without overflow; the ninth push overwrites the first.
// - Call and jump supply an 11-bit target within one 2K page.
// - Page bits of the target come from upper-latch bits 4 and 3.
// - The full 13-bit counter is pushed, so returns restore it completely.
// - The indirect data port has no storage; it only redirects accesses.
// - Port accesses act on the register-file location named by the pointer.
// - Reading the port through a pointer of zero returns zero.
// - Writing the port through a pointer of zero stores nothing.
// - Effective address joins pointer and bank bit; the bank bit is ignored.
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps

module pcs_core
  import pcs_pkg::*;
#(
  parameter int unsigned DEPTH = STACK_DEPTH
) (
  input  wire logic                      i_mclk,
  input  wire logic                      i_sys_rst,
  input  wire pcs_instr_type             i_instr,
  input  wire logic [BUS_ADDR_WIDTH-1:0] i_avs_address,
  input  wire logic                      i_avs_read,
  input  wire logic                      i_avs_write,
  input  wire logic [31:0]               i_avs_writedata,
  input  wire logic [3:0]                i_avs_byteenable,
  output logic      [31:0]               o_avs_readdata,
  output logic                           o_avs_waitrequest,
  output logic      [PC_WIDTH-1:0]       o_pc
);

  logic [PC_WIDTH-1:0]        pc_reg;
  logic [PC_HIGH_WIDTH-1:0]   latch_reg;
  logic [FILE_ADDR_WIDTH-1:0] pointer_reg;
  logic                       bank_reg;
  logic [STACK_PTR_WIDTH-1:0] sp_reg;
  logic [PC_WIDTH-1:0]        stack_mem [DEPTH];
  logic [7:0]                 file_mem [2**FILE_ADDR_WIDTH];
  logic                       wait_reg;
  logic [31:0]                rdata_reg;
  logic [31:0]                rdata_next;

  logic                       req;
  logic                       taken;
  logic                       wr_taken;
  logic                       push;
  logic                       pop;
  logic                       branch_event;
  logic                       is_file;
  logic [FILE_ADDR_WIDTH-1:0] file_addr;
  logic [FILE_ADDR_WIDTH-1:0] eff_addr;
  logic [8:0]                 eff_addr_full;
  logic [7:0]                 port_read;
  logic [STACK_PTR_WIDTH-1:0] sp_prev;
  logic [PC_WIDTH-1:0]        jump_dest;
  logic                       pcl_write;

  assign req          = i_avs_read | i_avs_write;
  assign taken        = req & ~wait_reg;
  assign wr_taken     = taken & i_avs_write;
  assign push         = i_instr.irq | i_instr.call;
  assign pop          = i_instr.ret & ~push;
  assign branch_event = i_instr.irq | i_instr.call | i_instr.jump | i_instr.ret;
  assign sp_prev      = sp_reg - STACK_PTR_WIDTH'(1);
  assign jump_dest    = {latch_reg[PC_HIGH_WIDTH-1:LATCH_JUMP_LSB], i_instr.target};

  assign is_file   = i_avs_address[8];
  assign file_addr = i_avs_address[FILE_ADDR_WIDTH-1:0];
  // The bank bit is carried in the address but never selects anything.
  assign eff_addr_full = {bank_reg, pointer_reg};
  assign eff_addr      = eff_addr_full[FILE_ADDR_WIDTH-1:0];
  // A pointer of zero names the port itself, which holds nothing.
  assign port_read = (eff_addr == FILE_ADDR_PORT) ? 8'h00 : file_mem[eff_addr];
  assign pcl_write = wr_taken & ~is_file & (i_avs_address == ADDR_PC_LOW_BYTE)
                     & i_avs_byteenable[0];

  // Bus answer: waitrequest drops for exactly one cycle, one cycle after the request rises.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~(req & wait_reg);
    end
  end

  // The stack and its pointer never appear here; the counter's high part is read only through the status word.
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (is_file) begin
      if (file_addr == FILE_ADDR_PORT) begin
        rdata_next[7:0] = port_read;
      end else begin
        rdata_next[7:0] = file_mem[file_addr];
      end
    end else begin
      unique case (i_avs_address)
        ADDR_PC_LOW_BYTE: rdata_next[7:0] = pc_reg[PC_LOW_WIDTH-1:0];
        ADDR_PC_UPPER:    rdata_next[PC_HIGH_WIDTH-1:0] = latch_reg;
        ADDR_IND_POINTER: rdata_next[POINTER_BANK_BIT:0] = {bank_reg, pointer_reg};
        ADDR_IND_PORT:    rdata_next[7:0] = port_read;
        ADDR_PC_STATUS:   rdata_next[PC_WIDTH-1:0] = pc_reg;
        default:          rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req & wait_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  // Program counter; interrupt, call, jump and return win over a coinciding low-byte write, which wins over a fetch.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pc_reg <= PC_RESET;
    end else if (i_instr.irq) begin
      pc_reg <= IRQ_VECTOR;
    end else if (i_instr.call | i_instr.jump) begin
      pc_reg <= jump_dest;
    end else if (i_instr.ret) begin
      pc_reg <= stack_mem[sp_prev];
    end else if (pcl_write) begin
      pc_reg <= {latch_reg, i_avs_writedata[PC_LOW_WIDTH-1:0]};
    end else if (i_instr.fetch) begin
      pc_reg <= pc_reg + PC_WIDTH'(1);
    end
  end

  // Hidden stack pointer wraps through all entries.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sp_reg <= STACK_PTR_RESET;
    end else if (push) begin
      sp_reg <= sp_reg + STACK_PTR_WIDTH'(1);
    end else if (pop) begin
      sp_reg <= sp_prev;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (push) begin
      stack_mem[sp_reg] <= pc_reg;
    end
  end

  // The upper latch changes only under software writes.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      latch_reg <= LATCH_RESET;
    end else if (wr_taken & ~is_file & (i_avs_address == ADDR_PC_UPPER)
                 & i_avs_byteenable[0]) begin
      latch_reg <= i_avs_writedata[PC_HIGH_WIDTH-1:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pointer_reg <= POINTER_RESET;
      bank_reg    <= 1'b0;
    end else if (wr_taken & ~is_file & (i_avs_address == ADDR_IND_POINTER)) begin
      if (i_avs_byteenable[0]) begin
        pointer_reg <= i_avs_writedata[FILE_ADDR_WIDTH-1:0];
      end
      if (i_avs_byteenable[1]) begin
        bank_reg <= i_avs_writedata[POINTER_BANK_BIT];
      end
    end
  end

  // Register file; writes through the port land on the pointed location.
  always_ff @(posedge i_mclk) begin
    if (wr_taken & i_avs_byteenable[0]) begin
      if ((is_file & (file_addr == FILE_ADDR_PORT))
          | (~is_file & (i_avs_address == ADDR_IND_PORT))) begin
        if (eff_addr != FILE_ADDR_PORT) begin
          file_mem[eff_addr] <= i_avs_writedata[7:0];
        end
      end else if (is_file) begin
        file_mem[file_addr] <= i_avs_writedata[7:0];
      end
    end
  end

  assign o_pc              = pc_reg;
  assign o_avs_readdata    = rdata_reg;
  assign o_avs_waitrequest = wait_reg;

  fetch_inc_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (i_instr.fetch && !branch_event && !pcl_write) |=> pc_reg == $past(pc_reg) + 13'd1)
    else $error("Sequential fetch did not add one.");

  call_target_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (i_instr.call && !i_instr.irq)
      |=> pc_reg == {$past(latch_reg[4:3]), $past(i_instr.target)})
    else $error("Call target not paged by upper latch.");

  call_return_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (i_instr.call && !i_instr.irq) ##1 (i_instr.ret && !push) |=> pc_reg == $past(pc_reg, 2))
    else $error("Return did not restore the pushed address.");

  irq_push_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_instr.irq |=> (pc_reg == IRQ_VECTOR) && (sp_reg == $past(sp_reg) + 3'd1))
    else $error("Interrupt branch did not push and vector.");

  latch_hold_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    ((push || pop) && !wr_taken) |=> $stable(latch_reg))
    else $error("Upper latch changed on a stack operation.");

  stack_wrap_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (push && sp_reg == 3'd7) |=> sp_reg == 3'd0)
    else $error("Stack pointer did not wrap.");

  pcl_load_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (pcl_write && !branch_event)
      |=> pc_reg == {$past(latch_reg), $past(i_avs_writedata[7:0])})
    else $error("Low byte write did not load the latch.");

  port_zero_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (taken && i_avs_read && !is_file && i_avs_address == ADDR_IND_PORT && eff_addr == 8'h00)
      |-> rdata_reg[7:0] == 8'h00)
    else $error("Port read through zero pointer not zero.");

  reset_pc_a: assert property (@(posedge i_mclk)
    i_sys_rst |=> (pc_reg == PC_RESET) && (sp_reg == STACK_PTR_RESET))
    else $error("Counter or stack pointer not cleared by reset.");

  jump_target_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (i_instr.jump && !i_instr.call && !i_instr.irq)
      |=> pc_reg == {$past(latch_reg[4:3]), $past(i_instr.target)})
    else $error("Jump target not paged by upper latch.");

  stack_pop_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    pop |=> sp_reg == $past(sp_reg) - 3'd1)
    else $error("Return did not step the stack pointer back.");

  bus_answer_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (req && wait_reg) |=> !wait_reg ##1 wait_reg)
    else $error("Waitrequest did not drop for one cycle.");

endmodule // pcs_core

// ### tb/tb_top.sv
// Self-checking bench for the program counter, return stack and indirect access block.
`timescale 1ns/100ps

module tb_top;
  import pcs_pkg::*;

  logic          i_mclk = 1'b0;
  logic          i_sys_rst = 1'b1;
  pcs_instr_type i_instr = '0;
  logic [8:0]    i_avs_address = 9'h000;
  logic          i_avs_read = 1'b0;
  logic          i_avs_write = 1'b0;
  logic [31:0]   i_avs_writedata = 32'h0;
  logic [3:0]    i_avs_byteenable = 4'h0;
  logic [31:0]   o_avs_readdata;
  logic          o_avs_waitrequest;
  logic [12:0]   o_pc;
  int            num_errors = 0;
  int            cmp_count = 0;
  logic [15:0]   lfsr_state = 16'h0001;
  int            m_pc;
  int            m_latch;
  int            m_sp;
  int            m_stk[8];
  logic [31:0]   rd;
  logic [10:0]   tgt;
  logic [7:0]    va;
  logic [7:0]    vb;
  pcs_instr_type iv;

  always #5 i_mclk = ~i_mclk;

  pcs_core #(.DEPTH(8)) pcs_core_inst (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_instr(i_instr),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_pc(o_pc)
  );

  function automatic logic [15:0] rnd();
    lfsr_state = {lfsr_state[14:0],
                  lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12] ^ lfsr_state[10]};
    return lfsr_state;
  endfunction

  task automatic test_done();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One bus transfer, held until waitrequest is sampled low; read data taken at that edge.
  task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge i_mclk);
    i_avs_address    <= a;
    i_avs_write      <= wr;
    i_avs_read       <= !wr;
    i_avs_writedata  <= d;
    i_avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      num_errors++;
      test_done();
    end
    q = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, a, d, be, rd);
  endtask

  task automatic rchk(input logic [8:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf, rd);
    chk(rd, exp);
  endtask

  // Kind: 0 fetch, 1 call, 2 jump, 3 return, 4 interrupt.
  task automatic ev(input int kind, input logic [10:0] t);
    pcs_instr_type v;
    v = '0;
    v.target = t;
    case (kind)
      0: begin v.fetch = 1'b1; m_pc = (m_pc + 1) % 8192; end
      1: begin v.call = 1'b1; m_stk[m_sp] = m_pc; m_sp = (m_sp + 1) % 8;
         m_pc = ((m_latch >> 3) << 11) + int'(t); end
      2: begin v.jump = 1'b1; m_pc = ((m_latch >> 3) << 11) + int'(t); end
      3: begin v.ret = 1'b1; m_sp = (m_sp + 7) % 8; m_pc = m_stk[m_sp]; end
      default: begin v.irq = 1'b1; m_stk[m_sp] = m_pc; m_sp = (m_sp + 1) % 8; m_pc = 4; end
    endcase
    @(posedge i_mclk);
    i_instr <= v;
    @(posedge i_mclk);
    i_instr <= '0;
    #1 chk(32'(o_pc), 32'(m_pc));
  endtask

  initial begin
    m_pc = 0;
    m_sp = 0;
    repeat (16) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    #1 chk(32'(o_pc), 32'h0);
    rchk(ADDR_PC_UPPER, 32'h0);
    m_latch = int'(rnd() & 16'h1f);
    wr(ADDR_PC_UPPER, 32'(m_latch), 4'h1);
    rchk(ADDR_PC_UPPER, 32'(m_latch));
    va = 8'(rnd());
    wr(ADDR_PC_LOW_BYTE, {24'hffffff, va}, 4'h1);
    m_pc = m_latch * 256 + int'(va);
    #1 chk(32'(o_pc), 32'(m_pc));
    rchk(ADDR_PC_LOW_BYTE, {24'h0, va});
    rchk(ADDR_PC_STATUS, 32'(m_pc));
    repeat (3) ev(0, 11'h0);
    for (int i = 0; i < 4; i++) begin
      m_latch = int'(rnd() & 16'h1f);
      wr(ADDR_PC_UPPER, 32'(m_latch), 4'h1);
      tgt = 11'(rnd());
      ev(2, tgt);
    end
    // Nine calls and an interrupt overrun the eight entries, then ten returns unwind them.
    for (int i = 0; i < 9; i++) begin
      tgt = 11'(rnd());
      ev(1, tgt);
    end
    ev(4, 11'h0);
    rchk(ADDR_PC_UPPER, 32'(m_latch));
    for (int i = 0; i < 10; i++) ev(3, 11'h0);
    // A call followed at once by a return comes back to the address before the call.
    tgt = 11'(rnd());
    iv = '0;
    iv.call = 1'b1;
    iv.target = tgt;
    @(posedge i_mclk);
    i_instr <= iv;
    iv = '0;
    iv.ret = 1'b1;
    @(posedge i_mclk);
    i_instr <= iv;
    #1 chk(32'(o_pc), 32'(((m_latch >> 3) << 11) + int'(tgt)));
    @(posedge i_mclk);
    i_instr <= '0;
    #1 chk(32'(o_pc), 32'(m_pc));
    rchk(ADDR_PC_UPPER, 32'(m_latch));
    va = 8'(rnd());
    vb = 8'(rnd());
    wr(ADDR_FILE_BASE + 9'h005, {24'h0, va}, 4'h1);
    wr(ADDR_FILE_BASE + 9'h006, {24'h0, vb}, 4'h1);
    wr(ADDR_IND_POINTER, 32'h105, 4'h3);
    rchk(ADDR_IND_POINTER, 32'h105);
    rchk(ADDR_IND_PORT, {24'h0, va});
    wr(ADDR_IND_POINTER, 32'h6, 4'h1);
    vb = 8'(rnd());
    wr(ADDR_IND_PORT, {24'h0, vb}, 4'h1);
    rchk(ADDR_FILE_BASE + 9'h006, {24'h0, vb});
    wr(ADDR_IND_POINTER, 32'h0, 4'h1);
    rchk(ADDR_IND_PORT, 32'h0);
    wr(ADDR_IND_PORT, 32'h5a, 4'h1);
    rchk(ADDR_IND_PORT, 32'h0);
    rchk(ADDR_FILE_BASE + 9'h005, {24'h0, va});
    rchk(ADDR_FILE_BASE + 9'h006, {24'h0, vb});
    wr(9'h005, 32'hff, 4'hf);
    rchk(9'h005, 32'h0);
    rchk(ADDR_PC_STATUS, 32'(m_pc));
    test_done();
  end
endmodule // tb_top
